// ==== tmwm_pkg.sv ====
// package for the timer waveform and compare output mode control block
// shared by the decoder and the bus-facing top module
package tmwm_pkg;
    // register index printed for control register a; its byte address is four times it
    localparam logic [7:0] CTRL_A_INDEX = 8'h2F;
    // byte addresses of the registers on the ahb-lite slave
    localparam logic [7:0] CTRL_A_OFFSET = {CTRL_A_INDEX[5:0], 2'h0};
    localparam logic [7:0] CTRL_B_OFFSET = 8'h30;
    localparam logic [7:0] PORT_CTRL_OFFSET = 8'h34;
    localparam logic [7:0] TIMING_OFFSET = 8'h38;
    localparam logic [7:0] STATUS_OFFSET = 8'h3C;
    // control register a fields
    localparam int CHAN_A_MODE_LSB = 6;
    localparam int CHAN_B_MODE_LSB = 4;
    localparam int WGM_LOW_LSB = 0;
    localparam logic [7:0] CTRL_A_WRITE_MASK = 8'hF3;
    // control register b fields
    localparam int WGM_HIGH_LSB = 3;
    localparam logic [7:0] CTRL_B_WRITE_MASK = 8'hDF;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // fixed top values
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] BOTTOM = 16'h0000;

    typedef enum logic [2:0] {
        TMWM_NORMAL,
        TMWM_CLEAR_ON_MATCH,
        TMWM_FAST_PWM,
        TMWM_PHASE_CORRECT,
        TMWM_PHASE_FREQ_CORRECT,
        TMWM_RESERVED
    } tmwm_kind_t;

    typedef enum logic [1:0] {
        TMWM_TOP_FIXED,
        TMWM_TOP_CMP_A,
        TMWM_TOP_CAPTURE
    } tmwm_top_src_t;

    // update point / overflow point
    typedef enum logic [1:0] {
        TMWM_AT_IMMEDIATE,
        TMWM_AT_TOP,
        TMWM_AT_BOTTOM,
        TMWM_AT_MAX
    } tmwm_point_t;
endpackage : tmwm_pkg

// ==== tmwm_mode_decode.sv ====
// waveform mode decoder: four-bit mode number to counting kind, top, update and overflow points
// purely combinational; the caller supplies compare value a and capture value
`timescale 1ns/1ps
module tmwm_mode_decode (
    // mode and top sources
    input wire logic [3:0] waveform_mode,
    input wire logic [15:0] compare_value_a,
    input wire logic [15:0] capture_value,
    // decoded
    output tmwm_pkg::tmwm_kind_t kind,
    output tmwm_pkg::tmwm_top_src_t top_src,
    output logic [15:0] top_value,
    output tmwm_pkg::tmwm_point_t update_point,
    output tmwm_pkg::tmwm_point_t overflow_point
);
    always_comb begin
        kind = tmwm_pkg::TMWM_RESERVED;
        top_src = tmwm_pkg::TMWM_TOP_FIXED;
        top_value = tmwm_pkg::TOP_MAX;
        update_point = tmwm_pkg::TMWM_AT_IMMEDIATE;
        overflow_point = tmwm_pkg::TMWM_AT_MAX;
        unique case (waveform_mode)
            4'h0: begin
                kind = tmwm_pkg::TMWM_NORMAL; // (R9)
            end
            4'h4, 4'hC: begin
                kind = tmwm_pkg::TMWM_CLEAR_ON_MATCH; // (R9)
                top_src = waveform_mode[3] ? tmwm_pkg::TMWM_TOP_CAPTURE
                                           : tmwm_pkg::TMWM_TOP_CMP_A;
            end
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin
                kind = tmwm_pkg::TMWM_PHASE_CORRECT; // (R10)
                update_point = tmwm_pkg::TMWM_AT_TOP;
                overflow_point = tmwm_pkg::TMWM_AT_BOTTOM;
                if (waveform_mode[3]) begin
                    top_src = waveform_mode[0] ? tmwm_pkg::TMWM_TOP_CMP_A
                                               : tmwm_pkg::TMWM_TOP_CAPTURE;
                end
            end
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
                kind = tmwm_pkg::TMWM_FAST_PWM; // (R11)
                update_point = tmwm_pkg::TMWM_AT_BOTTOM;
                overflow_point = tmwm_pkg::TMWM_AT_TOP;
                if (waveform_mode[3]) begin
                    top_src = waveform_mode[0] ? tmwm_pkg::TMWM_TOP_CMP_A
                                               : tmwm_pkg::TMWM_TOP_CAPTURE;
                end
            end
            4'h8, 4'h9: begin
                kind = tmwm_pkg::TMWM_PHASE_FREQ_CORRECT; // (R12)
                update_point = tmwm_pkg::TMWM_AT_BOTTOM;
                overflow_point = tmwm_pkg::TMWM_AT_BOTTOM;
                top_src = waveform_mode[0] ? tmwm_pkg::TMWM_TOP_CMP_A
                                           : tmwm_pkg::TMWM_TOP_CAPTURE;
            end
            // mode 13 stays reserved: outputs hold, no overflow point applies
            4'hD: begin
                kind = tmwm_pkg::TMWM_RESERVED; // (R13)
            end
        endcase
        unique case (top_src)
            tmwm_pkg::TMWM_TOP_CMP_A: top_value = compare_value_a;
            tmwm_pkg::TMWM_TOP_CAPTURE: top_value = capture_value;
            tmwm_pkg::TMWM_TOP_FIXED: begin
                unique case (waveform_mode[1:0])
                    2'h1: top_value = tmwm_pkg::TOP_8BIT;
                    2'h2: top_value = tmwm_pkg::TOP_9BIT;
                    2'h3: top_value = tmwm_pkg::TOP_10BIT;
                    2'h0: top_value = tmwm_pkg::TOP_MAX;
                endcase
            end
            default: top_value = tmwm_pkg::TOP_MAX;
        endcase
    end
endmodule : tmwm_mode_decode

// ==== tmwm_top.sv ====
// timer waveform mode and compare output mode control, with ahb-lite register slave
// assumes the counter core drives counter value, direction and a count enable;
// the pin drivers and port logic sit outside and use the pin override signals
//
// Functional notes
// (R1) nonzero output mode routes compare output to pin
// (R2) pin driven only when port direction is output
// (R3) non-pwm: disconnect, toggle, clear, set on match
// (R4) fast pwm: non-inverting or inverting, bottom restores
// (R5) pwm mode 1: toggle A only when bit3 set
// (R6) fast pwm compare equal top ignored, bottom acts
// (R7) dual slope: mode 2 clear up, set down
// (R8) control a bits 1:0 hold low mode bits
// (R9) normal/clear-on-match: immediate update, overflow at max
// (R10) phase correct: update at top, overflow at bottom
// (R11) fast pwm: update at bottom, overflow at top
// (R12) phase-frequency correct: update and overflow at bottom
// (R13) software must never select mode thirteen
// (R14) control b bits 4:3 hold high mode bits
// (R15) dual slope extremes give constant output levels
// (R16) control a bits 3:2 read zero, reset zero
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module tmwm_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // counter core
    input wire logic COUNT_EN,
    input wire logic [15:0] COUNTER_VALUE,
    input wire logic COUNT_DOWN,
    input wire logic [15:0] CAPTURE_VALUE,
    input wire logic [15:0] COMPARE_VALUE_A,
    input wire logic [15:0] COMPARE_VALUE_B,
    // decoded timing for the counter core
    output logic [15:0] TOP_VALUE,
    output logic COMPARE_UPDATE,
    output logic OVERFLOW_SET,
    // pins
    output logic COMPARE_OUT_A,
    output logic COMPARE_OUT_B,
    output logic PIN_OVERRIDE_A,
    output logic PIN_OVERRIDE_B,
    output logic PIN_OE_A_N,
    output logic PIN_OE_B_N
);
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [1:0] port_dir_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_next;
    logic [3:0] waveform_mode;
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [15:0] top_value;
    tmwm_pkg::tmwm_kind_t kind;
    tmwm_pkg::tmwm_top_src_t top_src;
    tmwm_pkg::tmwm_point_t update_point;
    tmwm_pkg::tmwm_point_t overflow_point;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic pwm_kind;
    logic dual_slope;
    logic out_a_reg;
    logic out_b_reg;
    logic out_a_next;
    logic out_b_next;
    logic update_reg;
    logic overflow_reg;

    // bus address phase
    logic addr_ok;
    assign addr_ok = HSEL && HREADY && HTRANS[1];

    assign chan_a_output_mode = ctrl_a_reg[tmwm_pkg::CHAN_A_MODE_LSB +: 2];
    assign chan_b_output_mode = ctrl_a_reg[tmwm_pkg::CHAN_B_MODE_LSB +: 2];
    assign waveform_mode = {ctrl_b_reg[tmwm_pkg::WGM_HIGH_LSB +: 2],
                            ctrl_a_reg[tmwm_pkg::WGM_LOW_LSB +: 2]}; // (R8) (R14)

    tmwm_mode_decode u_decode (
        .waveform_mode(waveform_mode),
        .compare_value_a(COMPARE_VALUE_A),
        .capture_value(CAPTURE_VALUE),
        .kind(kind),
        .top_src(top_src),
        .top_value(top_value),
        .update_point(update_point),
        .overflow_point(overflow_point)
    );

    assign at_top = COUNTER_VALUE == top_value;
    assign at_bottom = COUNTER_VALUE == tmwm_pkg::BOTTOM;
    assign at_max = COUNTER_VALUE == tmwm_pkg::TOP_MAX;
    assign pwm_kind = kind == tmwm_pkg::TMWM_FAST_PWM || dual_slope;
    assign dual_slope = kind == tmwm_pkg::TMWM_PHASE_CORRECT
                        || kind == tmwm_pkg::TMWM_PHASE_FREQ_CORRECT;

    // one output channel's next level; is_b selects the reserved-toggle case
    function automatic logic chan_next(
        input logic cur,
        input logic [1:0] mode,
        input logic is_b,
        input logic [15:0] cmp,
        input tmwm_pkg::tmwm_kind_t k,
        input logic wgm3,
        input logic [15:0] cnt,
        input logic [15:0] top,
        input logic down
    );
        logic match;
        logic res;
        match = cnt == cmp;
        res = cur;
        unique case (k)
            tmwm_pkg::TMWM_NORMAL, tmwm_pkg::TMWM_CLEAR_ON_MATCH: begin
                if (match) begin
                    unique case (mode) // (R3)
                        2'h1: res = ~cur;
                        2'h2: res = 1'b0;
                        2'h3: res = 1'b1;
                        2'h0: res = cur;
                    endcase
                end
            end
            tmwm_pkg::TMWM_FAST_PWM: begin
                if (mode == 2'h1) begin
                    if (wgm3 && !is_b && match) res = ~cur; // (R5)
                end else if (mode[1]) begin
                    // a match on top is dropped so the bottom action alone shapes the pulse
                    if (cnt == tmwm_pkg::BOTTOM) res = ~mode[0]; // (R4) (R6)
                    else if (match && cmp != top) res = mode[0]; // (R4) (R6)
                end
            end
            tmwm_pkg::TMWM_PHASE_CORRECT, tmwm_pkg::TMWM_PHASE_FREQ_CORRECT: begin
                if (mode == 2'h1) begin
                    if (wgm3 && !is_b && match) res = ~cur; // (R5)
                end else if (mode[1]) begin
                    // extremes: compare at bottom holds low, at top holds high (non-inverting)
                    if (cmp == tmwm_pkg::BOTTOM) res = mode[0]; // (R15)
                    else if (cmp >= top) res = ~mode[0]; // (R15)
                    else if (match) res = down ? ~mode[0] : mode[0]; // (R7)
                end
            end
            default: res = cur;
        endcase
        return res;
    endfunction : chan_next

    assign out_a_next = chan_next(out_a_reg, chan_a_output_mode, 1'b0, COMPARE_VALUE_A, kind,
                                  waveform_mode[3], COUNTER_VALUE, top_value, COUNT_DOWN);
    assign out_b_next = chan_next(out_b_reg, chan_b_output_mode, 1'b1, COMPARE_VALUE_B, kind,
                                  waveform_mode[3], COUNTER_VALUE, top_value, COUNT_DOWN);

    // compare output levels, advanced on timer clock enable
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end else if (COUNT_EN) begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
        end
    end

    // update and overflow pulses, one cycle after the counter state that earns them
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            update_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end else begin
            update_reg <= 1'b0;
            overflow_reg <= 1'b0;
            if (COUNT_EN) begin
                unique case (update_point)
                    tmwm_pkg::TMWM_AT_IMMEDIATE: update_reg <= 1'b1; // (R9)
                    tmwm_pkg::TMWM_AT_TOP: update_reg <= at_top; // (R10)
                    tmwm_pkg::TMWM_AT_BOTTOM: update_reg <= at_bottom; // (R11) (R12)
                    tmwm_pkg::TMWM_AT_MAX: update_reg <= at_max;
                endcase
                unique case (overflow_point)
                    tmwm_pkg::TMWM_AT_MAX: overflow_reg <= at_max
                        && kind != tmwm_pkg::TMWM_RESERVED; // (R9)
                    tmwm_pkg::TMWM_AT_BOTTOM: overflow_reg <= at_bottom; // (R10) (R12)
                    tmwm_pkg::TMWM_AT_TOP: overflow_reg <= at_top; // (R11)
                    tmwm_pkg::TMWM_AT_IMMEDIATE: overflow_reg <= 1'b0;
                endcase
            end
        end
    end

    // pin takeover: any set mode bit connects, unless pwm mode 1 (on A only with bit3 clear, on B always)
    always_comb begin
        PIN_OVERRIDE_A = |chan_a_output_mode; // (R1)
        PIN_OVERRIDE_B = |chan_b_output_mode; // (R1)
        if (pwm_kind && chan_a_output_mode == 2'h1 && !waveform_mode[3]) begin
            PIN_OVERRIDE_A = 1'b0; // (R5)
        end
        if (pwm_kind && chan_b_output_mode == 2'h1) begin
            PIN_OVERRIDE_B = 1'b0; // (R5)
        end
    end

    assign PIN_OE_A_N = !(PIN_OVERRIDE_A && port_dir_reg[0]); // (R2)
    assign PIN_OE_B_N = !(PIN_OVERRIDE_B && port_dir_reg[1]); // (R2)
    assign COMPARE_OUT_A = out_a_reg;
    assign COMPARE_OUT_B = out_b_reg;
    assign TOP_VALUE = top_value;
    assign COMPARE_UPDATE = update_reg;
    assign OVERFLOW_SET = overflow_reg;

    // bus write: capture address phase, write in the data phase
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && HWRITE;
            if (addr_ok) wr_addr_reg <= HADDR;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctrl_a_reg <= tmwm_pkg::CTRL_A_RESET; // (R16)
            ctrl_b_reg <= tmwm_pkg::CTRL_B_RESET;
            port_dir_reg <= 2'h0;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                tmwm_pkg::CTRL_A_OFFSET:
                    ctrl_a_reg <= HWDATA[7:0] & tmwm_pkg::CTRL_A_WRITE_MASK; // (R16)
                tmwm_pkg::CTRL_B_OFFSET:
                    ctrl_b_reg <= HWDATA[7:0] & tmwm_pkg::CTRL_B_WRITE_MASK;
                tmwm_pkg::PORT_CTRL_OFFSET:
                    port_dir_reg <= HWDATA[1:0];
                default: ;
            endcase
        end
    end

    // read data registered from the address phase so it stands in the data phase
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (HADDR)
            tmwm_pkg::CTRL_A_OFFSET: rdata_next = {24'h000000, ctrl_a_reg};
            tmwm_pkg::CTRL_B_OFFSET: rdata_next = {24'h000000, ctrl_b_reg};
            tmwm_pkg::PORT_CTRL_OFFSET: rdata_next = {30'h0, port_dir_reg};
            tmwm_pkg::TIMING_OFFSET: rdata_next = {16'h0000, top_value};
            tmwm_pkg::STATUS_OFFSET: rdata_next = {22'h0, PIN_OVERRIDE_B, PIN_OVERRIDE_A,
                                                   out_b_reg, out_a_reg, 1'b0, kind,
                                                   top_src};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= rdata_next;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
endmodule : tmwm_top

// ==== tmwm_chk.sv ====
// assertion checker for the timer waveform mode control block
// sees only top ports; shadows control and direction writes from the bus itself
`timescale 1ns/1ps
module tmwm_chk (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // bus
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    // counter side
    input wire logic COUNT_EN,
    input wire logic [15:0] COUNTER_VALUE,
    input wire logic COUNT_DOWN,
    input wire logic [15:0] COMPARE_VALUE_A,
    input wire logic [15:0] TOP_VALUE,
    input wire logic COMPARE_UPDATE,
    input wire logic OVERFLOW_SET,
    // channel a pin
    input wire logic COMPARE_OUT_A,
    input wire logic PIN_OVERRIDE_A,
    input wire logic PIN_OE_A_N
);
    logic [7:0] ctl_a, ctl_b, wr_addr;
    logic [1:0] dir;
    logic wr_pend;
    logic [3:0] mode;
    logic [1:0] com_a;
    logic hit_a;
    logic pwm_m;
    assign mode = {ctl_b[4:3], ctl_a[1:0]};
    assign com_a = ctl_a[7:6];
    // pwm kinds: every mode but normal, the two clear-on-match modes and the reserved one
    assign pwm_m = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
    assign hit_a = COUNT_EN && (COUNTER_VALUE == COMPARE_VALUE_A);
    // the shadow lands on the same edge as the slave's own register
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_pend <= 1'h0;
            wr_addr <= 8'h00;
            ctl_a <= 8'h00;
            ctl_b <= 8'h00;
            dir <= 2'h0;
        end else begin
            wr_pend <= HSEL && HREADY && HTRANS[1] && HWRITE;
            wr_addr <= HADDR;
            if (wr_pend && wr_addr == tmwm_pkg::CTRL_A_OFFSET) ctl_a <= HWDATA[7:0];
            if (wr_pend && wr_addr == tmwm_pkg::CTRL_B_OFFSET) ctl_b <= HWDATA[7:0];
            if (wr_pend && wr_addr == tmwm_pkg::PORT_CTRL_OFFSET) dir <= HWDATA[1:0];
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    a_override_link: assert property (PIN_OVERRIDE_A == (com_a != 2'h0
        && !(pwm_m && com_a == 2'h1 && !mode[3])))
        else $error("override does not follow channel a output mode");
    a_oe_gating: assert property (PIN_OE_A_N == !(PIN_OVERRIDE_A && dir[0]))
        else $error("pin driver enable wrong for channel a");
    a_ctc_toggle: assert property ((mode == 4'h4 && com_a == 2'h1 && hit_a) |=>
        (COMPARE_OUT_A != $past(COMPARE_OUT_A))) else $error("no toggle on match");
    a_fast_bottom: assert property ((mode == 4'h5 && com_a == 2'h2 && COUNT_EN &&
        COUNTER_VALUE == 16'h0000) |=> COMPARE_OUT_A) else $error("no set at bottom");
    a_dual_upclear: assert property ((mode == 4'h1 && com_a == 2'h2 && hit_a && !COUNT_DOWN
        && COMPARE_VALUE_A != 16'h0000 && COMPARE_VALUE_A < 16'h00FF) |=> !COMPARE_OUT_A)
        else $error("no clear on up-count match");
    a_fixed_top: assert property ((mode == 4'h1) |-> (TOP_VALUE == 16'h00FF))
        else $error("wrong fixed top");
    a_dual_update: assert property ((mode == 4'h1 && COUNT_EN && COUNTER_VALUE == 16'h00FF)
        |=> COMPARE_UPDATE ##1 !COMPARE_UPDATE) else $error("update pulse not at top");
    a_fast_overflow: assert property ((mode == 4'h5 && COUNT_EN &&
        COUNTER_VALUE == 16'h00FF) |=> OVERFLOW_SET) else $error("no overflow at top");
    a_read_reserved: assert property ((HSEL && HREADY && HTRANS[1] && !HWRITE &&
        HADDR == tmwm_pkg::CTRL_A_OFFSET) |=> ((HRDATA & 32'hFFFFFF0C) == 32'h00000000))
        else $error("reserved control bits read nonzero");
    c_fast_ovf: cover property (mode == 4'h5 && OVERFLOW_SET);
    c_ctc_out: cover property (mode == 4'h4 && COMPARE_OUT_A);
    c_dual_upd: cover property (mode == 4'h1 && COMPARE_UPDATE);
endmodule : tmwm_chk

bind tmwm_top tmwm_chk u_chk (
    .SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HWDATA, .HRDATA,
    .COUNT_EN, .COUNTER_VALUE, .COUNT_DOWN, .COMPARE_VALUE_A, .TOP_VALUE,
    .COMPARE_UPDATE, .OVERFLOW_SET, .COMPARE_OUT_A, .PIN_OVERRIDE_A, .PIN_OE_A_N
);

// ==== tmwm_cnt_model.sv ====
// counter core stand-in: counter value, slope direction and count enable
// assumes top comes from the block's decoded top output
`timescale 1ns/1ps
module tmwm_cnt_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic dual,
    input wire logic [15:0] top,
    // counter
    output logic en,
    output logic [15:0] cnt,
    output logic dn
);
    assign en = run;
    // stopping returns to bottom so every run starts at a known phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
            dn <= 1'h0;
        end else if (!run) begin
            cnt <= 16'h0000;
            dn <= 1'h0;
        end else if (!dual) begin
            cnt <= (cnt >= top) ? 16'h0000 : cnt + 16'h0001;
        end else if (!dn) begin
            cnt <= cnt + 16'h0001;
            dn <= (cnt + 16'h0001 == top);
        end else begin
            cnt <= cnt - 16'h0001;
            dn <= (cnt != 16'h0001);
        end
    end
endmodule : tmwm_cnt_model

// ==== tmwm_top_test.sv ====
// self-checking bench for the timer waveform mode control block
// ahb-lite master on the register side, counter core model on the counter side
`timescale 1ns/1ps
module tmwm_top_test;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, q;
    logic hready, hresp, en, dn, upd, ovf, out_a, out_b, ovr_a, ovr_b, oe_a_n, oe_b_n;
    logic [15:0] cva = 16'h0000;
    logic [15:0] cvb = 16'h0000;
    logic [15:0] cap = 16'h0ABC;
    logic [15:0] cnt, top;
    logic run = 1'h0;
    logic dual = 1'h0;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int ha, hb, ov, up;
    always #10 clk = ~clk;
    tmwm_top dut (
        .SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .COUNT_EN(en), .COUNTER_VALUE(cnt),
        .COUNT_DOWN(dn), .CAPTURE_VALUE(cap), .COMPARE_VALUE_A(cva), .COMPARE_VALUE_B(cvb),
        .TOP_VALUE(top), .COMPARE_UPDATE(upd), .OVERFLOW_SET(ovf), .COMPARE_OUT_A(out_a),
        .COMPARE_OUT_B(out_b), .PIN_OVERRIDE_A(ovr_a), .PIN_OVERRIDE_B(ovr_b),
        .PIN_OE_A_N(oe_a_n), .PIN_OE_B_N(oe_b_n)
    );
    tmwm_cnt_model u_cnt (.clk(clk), .rst(rst), .run(run), .dual(dual), .top(top),
        .en(en), .cnt(cnt), .dn(dn));
    task automatic test_done();
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; read data is taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h00000000);
        chk(q, exp);
    endtask : rd
    // the extra edge lets the register update land before outputs are looked at
    task automatic setm(input logic [3:0] m, input logic [3:0] com);
        bus(1'h1, tmwm_pkg::CTRL_B_OFFSET, {27'h0, m[3:2], 3'h0});
        bus(1'h1, tmwm_pkg::CTRL_A_OFFSET, {24'h0, com, 2'h0, m[1:0]});
        @(posedge clk);
    endtask : setm
    // one warm-up period, then counts over whole periods so the phase does not matter
    task automatic run_check(input int warm, input int n, input int ea, input int eb,
            input int eo, input int eu);
        run <= 1'h1;
        repeat (warm) @(posedge clk);
        ha = 0;
        hb = 0;
        ov = 0;
        up = 0;
        repeat (n) begin
            @(posedge clk);
            ha += int'(out_a);
            hb += int'(out_b);
            ov += int'(ovf);
            up += int'(upd);
        end
        run <= 1'h0;
        chk(ha, ea);
        chk(hb, eb);
        chk(ov, eo);
        chk(up, eu);
    endtask : run_check
    function automatic logic [15:0] exp_top(input int m);
        case (m)
            0: return 16'hFFFF;
            1, 5: return 16'h00FF;
            2, 6: return 16'h01FF;
            3, 7: return 16'h03FF;
            4, 9, 11, 15: return cva;
            default: return cap;
        endcase
    endfunction : exp_top
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rd(tmwm_pkg::CTRL_A_OFFSET, 32'h00000000);
        rd(tmwm_pkg::CTRL_B_OFFSET, 32'h00000000);
        chk({ovr_a, oe_a_n}, 2'h1);
        bus(1'h1, tmwm_pkg::CTRL_A_OFFSET, 32'hFFFFFFFF);
        rd(tmwm_pkg::CTRL_A_OFFSET, 32'h000000F3);
        chk({ovr_b, ovr_a, oe_b_n, oe_a_n}, 4'hF);
        bus(1'h1, tmwm_pkg::PORT_CTRL_OFFSET, 32'h00000003);
        rd(8'h00, 32'h00000000);
        chk({hresp, oe_b_n, oe_a_n}, 3'h0);
        bus(1'h1, tmwm_pkg::CTRL_B_OFFSET, 32'hFFFFFFFF);
        rd(tmwm_pkg::CTRL_B_OFFSET, 32'h000000DF);
        cva <= 16'h1234;
        for (int i = 0; i < 16; i++) begin
            if (i != 13) begin
                setm(4'(i), 4'h0);
                chk(top, exp_top(i));
            end
        end
        setm(4'h5, 4'h5);
        chk({ovr_b, ovr_a}, 2'h0);
        setm(4'hF, 4'h5);
        chk({ovr_b, ovr_a}, 2'h1);
        cva <= 16'h0010;
        cvb <= 16'h0005;
        setm(4'h4, 4'h6);
        run_check(17, 34, 17, 0, 0, 34);
        cva <= 16'h0040;
        cvb <= 16'h00FF;
        setm(4'h5, 4'hB);
        run_check(256, 512, 128, 0, 2, 2);
        dual <= 1'h1;
        setm(4'h1, 4'hA);
        run_check(510, 1020, 256, 1020, 2, 2);
        test_done();
    end
endmodule : tmwm_top_test
